// [logic/oeuc_regs.svh]
// Register offsets, reset values and field positions of the output event update block.
// Assumes an 8-bit register port and eight general outputs.
// Functional notes
// - Output 5 has 8-bit alert mask; set bit n enables channel n; resets to channel 4.
// - Output 6 has 8-bit alert mask; set bits enable, cleared bits block channels.
// - Output 7 has 8-bit alert mask; reset value selects channel 6.
// - Channels 0-3 hold 2-bit zero-cross codes; upper bit rising level, lower falling.
// - Code 01 follows inverted zero-cross signal; code 10 follows it directly.
// - Code 00 drives low on both edges; code 11 drives high on both edges.
// - Zero-cross level taken only while that output's zero-cross enable bit is set.
// - Alert update happens only while that output's alert update enable bit is set.
`ifndef OEUC_REGS_SVH
`define OEUC_REGS_SVH

// Register offsets
`define OEUC_ADDR_OUT5_MASK   8'hcd
`define OEUC_ADDR_OUT6_MASK   8'hcf
`define OEUC_ADDR_OUT7_MASK   8'hd1
`define OEUC_ADDR_ZC_CODES    8'he3
`define OEUC_ADDR_ZC_EN       8'he7
`define OEUC_ADDR_TRIG_EN     8'he9
`define OEUC_ADDR_TRIG_VAL    8'heb
`define OEUC_ADDR_OUT_LEVELS  8'hf0

// Reset values
`define OEUC_RST_OUT5_MASK    8'h10
`define OEUC_RST_OUT6_MASK    8'h80
`define OEUC_RST_OUT7_MASK    8'h40
`define OEUC_RST_ZERO         8'h00

// Channels that carry a zero-cross code, and outputs that carry an alert mask
`define OEUC_ZC_CHANS         8'h0f
`define OEUC_TRIG_CHANS       8'he0
`define OEUC_FIRST_MASK_CHAN  5

// Code field layout
`define OEUC_CODE_W           2
`define OEUC_CODE_RISE_BIT    1
`define OEUC_CODE_FALL_BIT    0
`define OEUC_CODE_LOW         2'h0
`define OEUC_CODE_INV         2'h1
`define OEUC_CODE_FOLLOW      2'h2
`define OEUC_CODE_HIGH        2'h3

`endif

// [logic/oeuc_pkg.sv]
// Types shared by the output event update block.
// Assumes the constants header is included by users of the offsets.
`default_nettype none
package oeuc_pkg;
	typedef logic [7:0] oeuc_byte_t;
	typedef logic [1:0] oeuc_code_t;

	// One register port request
	typedef struct packed {
		oeuc_byte_t addr;
		oeuc_byte_t wdata;
		logic       wr;
		logic       rd;
	} oeuc_bus_s;
endpackage
`default_nettype wire

// [logic/oeuc_chan.sv]
// One general output: launches levels on alert hits and on zero-cross edges.
// Assumes all inputs are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "oeuc_regs.svh"
module oeuc_chan (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             zc_en,
	input  wire oeuc_pkg::oeuc_code_t code,
	input  wire logic             zc_now,
	input  wire logic             trig_en,
	input  wire logic             trig_hit,
	input  wire logic             trig_level,
	output logic                  level_q
);
	import oeuc_pkg::*;

	logic zc_prev_q;
	logic zc_ok_q;
	logic zc_rise;
	logic zc_fall;

	// Previous zero-cross sample; first sample after reset is not an edge
	always_ff @(posedge clk) begin
		if (rst) begin
			zc_prev_q <= 1'b0;
			zc_ok_q   <= 1'b0;
		end else begin
			zc_prev_q <= zc_now;
			zc_ok_q   <= 1'b1;
		end
	end

	assign zc_rise = zc_ok_q & zc_now & ~zc_prev_q;
	assign zc_fall = zc_ok_q & ~zc_now & zc_prev_q;

	// Launched level; alert update wins over a coincident edge
	always_ff @(posedge clk) begin
		if (rst) begin
			level_q <= 1'b0;
		end else if (trig_en && trig_hit) begin
			level_q <= trig_level;
		end else if (zc_en && zc_rise) begin
			level_q <= code[`OEUC_CODE_RISE_BIT];
		end else if (zc_en && zc_fall) begin
			level_q <= code[`OEUC_CODE_FALL_BIT];
		end
	end
endmodule
`default_nettype wire

// [logic/oeuc_top.sv]
// Top of the output event update block: register port, per-output masks and codes.
// Assumes synchronous inputs, one clock and a strobe-based register port.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "oeuc_regs.svh"
module oeuc_top (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire oeuc_pkg::oeuc_bus_s   bus,
	output logic [7:0]                 rdata_q,
	input  wire logic [7:0]            alert_flags,
	input  wire logic [7:0]            zero_cross_signal,
	output logic [7:0]                 general_output
);
	import oeuc_pkg::*;

	oeuc_byte_t out5_mask_q;
	oeuc_byte_t out6_mask_q;
	oeuc_byte_t out7_mask_q;
	oeuc_byte_t zc_codes_q;
	oeuc_byte_t zc_en_q;
	oeuc_byte_t trig_en_q;
	oeuc_byte_t trig_val_q;
	oeuc_byte_t rdata_d;
	oeuc_byte_t chan_mask [8];
	oeuc_code_t chan_code [8];
	logic [7:0] chan_hit;
	logic [7:0] chan_zc_en;
	logic [7:0] chan_trig_en;

	// Outputs that own a zero-cross code, and outputs that own an alert mask
	localparam oeuc_byte_t zc_chan_set   = `OEUC_ZC_CHANS;
	localparam oeuc_byte_t trig_chan_set = `OEUC_TRIG_CHANS;

	// Alert mask of output 5
	always_ff @(posedge clk) begin
		if (rst) begin
			out5_mask_q <= `OEUC_RST_OUT5_MASK;
		end else if (bus.wr && bus.addr == `OEUC_ADDR_OUT5_MASK) begin
			out5_mask_q <= bus.wdata;
		end
	end

	// Alert mask of output 6
	always_ff @(posedge clk) begin
		if (rst) begin
			out6_mask_q <= `OEUC_RST_OUT6_MASK;
		end else if (bus.wr && bus.addr == `OEUC_ADDR_OUT6_MASK) begin
			out6_mask_q <= bus.wdata;
		end
	end

	// Alert mask of output 7
	always_ff @(posedge clk) begin
		if (rst) begin
			out7_mask_q <= `OEUC_RST_OUT7_MASK;
		end else if (bus.wr && bus.addr == `OEUC_ADDR_OUT7_MASK) begin
			out7_mask_q <= bus.wdata;
		end
	end

	// Zero-cross codes of channels 0 to 3
	always_ff @(posedge clk) begin
		if (rst) begin
			zc_codes_q <= `OEUC_RST_ZERO;
		end else if (bus.wr && bus.addr == `OEUC_ADDR_ZC_CODES) begin
			zc_codes_q <= bus.wdata;
		end
	end

	// Zero-cross update enables
	always_ff @(posedge clk) begin
		if (rst) begin
			zc_en_q <= `OEUC_RST_ZERO;
		end else if (bus.wr && bus.addr == `OEUC_ADDR_ZC_EN) begin
			zc_en_q <= bus.wdata;
		end
	end

	// Alert update enables
	always_ff @(posedge clk) begin
		if (rst) begin
			trig_en_q <= `OEUC_RST_ZERO;
		end else if (bus.wr && bus.addr == `OEUC_ADDR_TRIG_EN) begin
			trig_en_q <= bus.wdata;
		end
	end

	// Levels launched on an alert update
	always_ff @(posedge clk) begin
		if (rst) begin
			trig_val_q <= `OEUC_RST_ZERO;
		end else if (bus.wr && bus.addr == `OEUC_ADDR_TRIG_VAL) begin
			trig_val_q <= bus.wdata;
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		unique case (bus.addr)
			`OEUC_ADDR_OUT5_MASK:  rdata_d = out5_mask_q;
			`OEUC_ADDR_OUT6_MASK:  rdata_d = out6_mask_q;
			`OEUC_ADDR_OUT7_MASK:  rdata_d = out7_mask_q;
			`OEUC_ADDR_ZC_CODES:   rdata_d = zc_codes_q;
			`OEUC_ADDR_ZC_EN:      rdata_d = zc_en_q;
			`OEUC_ADDR_TRIG_EN:    rdata_d = trig_en_q;
			`OEUC_ADDR_TRIG_VAL:   rdata_d = trig_val_q;
			`OEUC_ADDR_OUT_LEVELS: rdata_d = general_output;
			default:               rdata_d = `OEUC_RST_ZERO;
		endcase
	end

	// Read data stand only in the cycle after the read strobe
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= `OEUC_RST_ZERO;
		end else if (bus.rd) begin
			rdata_q <= rdata_d;
		end else begin
			rdata_q <= `OEUC_RST_ZERO;
		end
	end

	// Per-output mask and code selection, one instance per output
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_chan
			if (i == `OEUC_FIRST_MASK_CHAN) begin : g_m5
				assign chan_mask[i] = out5_mask_q;
			end else if (i == `OEUC_FIRST_MASK_CHAN + 1) begin : g_m6
				assign chan_mask[i] = out6_mask_q;
			end else if (i == `OEUC_FIRST_MASK_CHAN + 2) begin : g_m7
				assign chan_mask[i] = out7_mask_q;
			end else begin : g_m0
				assign chan_mask[i] = `OEUC_RST_ZERO;
			end
			if (i < 4) begin : g_code
				assign chan_code[i] = zc_codes_q[`OEUC_CODE_W*i +: `OEUC_CODE_W];
			end else begin : g_nocode
				assign chan_code[i] = `OEUC_CODE_LOW;
			end
			assign chan_hit[i]     = |(alert_flags & chan_mask[i]);
			assign chan_zc_en[i]   = zc_en_q[i] & zc_chan_set[i];
			assign chan_trig_en[i] = trig_en_q[i] & trig_chan_set[i];

			oeuc_chan u_chan (
				.clk        (clk),
				.rst        (rst),
				.zc_en      (chan_zc_en[i]),
				.code       (chan_code[i]),
				.zc_now     (zero_cross_signal[i]),
				.trig_en    (chan_trig_en[i]),
				.trig_hit   (chan_hit[i]),
				.trig_level (trig_val_q[i]),
				.level_q    (general_output[i])
			);
		end
	endgenerate

	// Helper edge detection for the checks below
	logic [7:0] chk_prev_q;
	logic       chk_ok_q;
	logic [7:0] chk_edge;

	always_ff @(posedge clk) begin
		if (rst) begin
			chk_prev_q <= `OEUC_RST_ZERO;
			chk_ok_q   <= 1'b0;
		end else begin
			chk_prev_q <= zero_cross_signal;
			chk_ok_q   <= 1'b1;
		end
	end

	assign chk_edge = {8{chk_ok_q}} & (zero_cross_signal ^ chk_prev_q);

	chk_mask5_reset: assert property (@(posedge clk) rst |=> out5_mask_q == `OEUC_RST_OUT5_MASK)
		else $error("output 5 mask reset value wrong");

	chk_mask5_launch: assert property (@(posedge clk) disable iff (rst)
		(trig_en_q[5] && (alert_flags & out5_mask_q) != 8'h00)
		|=> general_output[5] == $past(trig_val_q[5]))
		else $error("output 5 missed a selected alert");

	chk_mask5_block: assert property (@(posedge clk) disable iff (rst)
		!(trig_en_q[5] && (alert_flags & out5_mask_q) != `OEUC_RST_ZERO)
		|=> $stable(general_output[5]))
		else $error("output 5 changed without an enabled alert");

	chk_mask6_reset: assert property (@(posedge clk) rst |=> out6_mask_q == `OEUC_RST_OUT6_MASK)
		else $error("output 6 mask reset value wrong");

	chk_mask6_launch: assert property (@(posedge clk) disable iff (rst)
		(trig_en_q[6] && (alert_flags & out6_mask_q) != `OEUC_RST_ZERO)
		|=> general_output[6] == $past(trig_val_q[6]))
		else $error("output 6 missed a selected alert");

	chk_mask6_block: assert property (@(posedge clk) disable iff (rst)
		((alert_flags & out6_mask_q) == 8'h00) |=> $stable(general_output[6]))
		else $error("output 6 changed without a selected alert");

	chk_mask7_reset: assert property (@(posedge clk) rst |=> out7_mask_q == `OEUC_RST_OUT7_MASK)
		else $error("output 7 mask reset value wrong");

	chk_mask7_launch: assert property (@(posedge clk) disable iff (rst)
		(trig_en_q[7] && (alert_flags & out7_mask_q) != `OEUC_RST_ZERO)
		|=> general_output[7] == $past(trig_val_q[7]))
		else $error("output 7 missed a selected alert");

	chk_mask7_block: assert property (@(posedge clk) disable iff (rst)
		((alert_flags & out7_mask_q) == `OEUC_RST_ZERO) |=> $stable(general_output[7]))
		else $error("output 7 changed without a selected alert");

	chk_codes_reset: assert property (@(posedge clk) rst |=> zc_codes_q == `OEUC_RST_ZERO)
		else $error("zero-cross codes reset value wrong");

	chk_code_rise: assert property (@(posedge clk) disable iff (rst)
		(zc_en_q[0] && chk_edge[0] && zero_cross_signal[0])
		|=> general_output[0] == $past(zc_codes_q[`OEUC_CODE_RISE_BIT]))
		else $error("channel 0 rising edge level wrong");

	chk_code_fall: assert property (@(posedge clk) disable iff (rst)
		(zc_en_q[0] && chk_edge[0] && !zero_cross_signal[0])
		|=> general_output[0] == $past(zc_codes_q[`OEUC_CODE_FALL_BIT]))
		else $error("channel 0 falling edge level wrong");

	chk_code_follow: assert property (@(posedge clk) disable iff (rst)
		(zc_en_q[1] && zc_codes_q[3:2] == `OEUC_CODE_FOLLOW && chk_edge[1])
		|=> general_output[1] == $past(zero_cross_signal[1]))
		else $error("channel 1 does not follow zero-cross");

	chk_code_invert: assert property (@(posedge clk) disable iff (rst)
		(zc_en_q[1] && zc_codes_q[3:2] == `OEUC_CODE_INV && chk_edge[1])
		|=> general_output[1] == !$past(zero_cross_signal[1]))
		else $error("channel 1 does not follow inverted zero-cross");

	chk_code_high: assert property (@(posedge clk) disable iff (rst)
		(zc_en_q[2] && zc_codes_q[5:4] == `OEUC_CODE_HIGH && chk_edge[2]) |=> general_output[2])
		else $error("channel 2 not high after edge");

	chk_code_low: assert property (@(posedge clk) disable iff (rst)
		(zc_en_q[3] && zc_codes_q[7:6] == `OEUC_CODE_LOW && chk_edge[3]) |=> !general_output[3])
		else $error("channel 3 not low after edge");

	chk_enables_reset: assert property (@(posedge clk) rst |=> (zc_en_q | trig_en_q) == `OEUC_RST_ZERO)
		else $error("update enables reset value wrong");

	chk_zc_disabled: assert property (@(posedge clk) disable iff (rst)
		!zc_en_q[0] |=> $stable(general_output[0]))
		else $error("channel 0 changed with zero-cross update off");

	chk_trig_disabled: assert property (@(posedge clk) disable iff (rst)
		!trig_en_q[7] |=> $stable(general_output[7]))
		else $error("output 7 changed with alert update off");

	chk_out4_low: assert property (@(posedge clk) disable iff (rst)
		general_output[4] == 1'b0)
		else $error("output 4 left its low level");

	chk_level_hold: assert property (@(posedge clk) disable iff (rst)
		!chk_edge[2] ##1 !chk_edge[2] |-> $stable(general_output[2]))
		else $error("channel 2 level not held between edges");

	chk_low_hold: assert property (@(posedge clk) disable iff (rst)
		chk_edge[3:0] == 4'h0 |=> $stable(general_output[3:0]))
		else $error("zero-cross outputs changed without an edge");

	chk_read_slot: assert property (@(posedge clk) disable iff (rst)
		!bus.rd |=> rdata_q == 8'h00)
		else $error("read data outside its slot");
endmodule
`default_nettype wire

// [bench/oeuc_top_tb_top.sv]
// Self-checking bench for the output event update block.
// Assumes reads answer one cycle after the strobe and outputs launch one cycle after a cause.
`timescale 1ns/1ps
`default_nettype none
`include "oeuc_regs.svh"
module oeuc_top_tb_top;
	import oeuc_pkg::*;
	logic       clk;
	logic       rst;
	oeuc_bus_s  bus;
	logic [7:0] rdata_q;
	logic [7:0] alert_flags;
	logic [7:0] zero_cross_signal;
	logic [7:0] general_output;
	int         bad_count;
	int         checks_done;
	logic [7:0] word;
	logic [7:0] got;
	logic [3:0] rise_exp;
	logic [3:0] fall_exp;
	logic [7:0] reg_addr [5];
	logic [7:0] reg_init [5];

	oeuc_top i_oeuc_top (
		.clk               (clk),
		.rst               (rst),
		.bus               (bus),
		.rdata_q           (rdata_q),
		.alert_flags       (alert_flags),
		.zero_cross_signal (zero_cross_signal),
		.general_output    (general_output)
	);

	// Free-running clock, 40 ns period
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Counts a comparison and reports a mismatch
	task automatic compare(input logic [7:0] seen, input logic [7:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t %s: saw %h, expected %h", $time, what, seen, exp);
		end
	endtask

	// One-cycle write strobe
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask

	// One-cycle read strobe, data sampled in the following cycle
	task automatic expect_read(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		#1;
		got = rdata_q;
		compare(got, exp, what);
	endtask

	// Applies new input levels and lets the launch land
	task automatic drive(input logic [7:0] zc, input logic [7:0] af);
		@(posedge clk);
		zero_cross_signal <= zc;
		alert_flags <= af;
		repeat (3) @(posedge clk);
		#1;
	endtask

	// Prints the counts and the verdict, then stops
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Cuts a hang short
	initial begin
		repeat (3000) @(posedge clk);
		bad_count++;
		conclude();
	end

	// Main sequence
	initial begin
		bus = '0;
		alert_flags = 8'h00;
		zero_cross_signal = 8'h00;
		rst = 1'b1;
		bad_count = 0;
		checks_done = 0;
		reg_addr = '{`OEUC_ADDR_OUT5_MASK, `OEUC_ADDR_OUT6_MASK, `OEUC_ADDR_OUT7_MASK, `OEUC_ADDR_ZC_CODES, 8'hce};
		reg_init = '{8'h10, 8'h80, 8'h40, 8'h00, 8'h00};
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		// Reset values, unmapped address reads zero
		for (int i = 0; i < 5; i++) begin
			expect_read(reg_addr[i], reg_init[i], "reset value");
		end
		compare(general_output, 8'h00, "outputs after reset");
		// Masks are writable and independent
		reg_write(`OEUC_ADDR_OUT5_MASK, 8'h01);
		reg_write(`OEUC_ADDR_OUT6_MASK, 8'h02);
		reg_write(`OEUC_ADDR_OUT7_MASK, 8'h04);
		expect_read(`OEUC_ADDR_OUT5_MASK, 8'h01, "out5 mask");
		expect_read(`OEUC_ADDR_OUT6_MASK, 8'h02, "out6 mask");
		expect_read(`OEUC_ADDR_OUT7_MASK, 8'h04, "out7 mask");
		// Every code on every channel, rotated so fields are told apart
		reg_write(`OEUC_ADDR_ZC_EN, 8'h0f);
		for (int k = 0; k < 4; k++) begin
			word = {2'(k + 3), 2'(k + 2), 2'(k + 1), 2'(k)};
			for (int n = 0; n < 4; n++) begin
				rise_exp[n] = word[2 * n + 1];
				fall_exp[n] = word[2 * n];
			end
			reg_write(`OEUC_ADDR_ZC_CODES, word);
			expect_read(`OEUC_ADDR_ZC_CODES, word, "code readback");
			drive(8'h0f, 8'h00);
			compare({4'h0, general_output[3:0]}, {4'h0, rise_exp}, "rising launch");
			drive(8'h00, 8'h00);
			compare({4'h0, general_output[3:0]}, {4'h0, fall_exp}, "falling launch");
		end
		// Disabled zero-cross update leaves outputs alone
		reg_write(`OEUC_ADDR_ZC_EN, 8'h00);
		reg_write(`OEUC_ADDR_ZC_CODES, 8'hff);
		drive(8'h0f, 8'h00);
		compare({4'h0, general_output[3:0]}, {4'h0, fall_exp}, "zc disabled");
		// Alert-driven launches through each mask
		reg_write(`OEUC_ADDR_TRIG_VAL, 8'he0);
		reg_write(`OEUC_ADDR_TRIG_EN, 8'he0);
		drive(8'h0f, 8'h08);
		compare({5'h0, general_output[7:5]}, 8'h00, "unselected alert");
		drive(8'h0f, 8'h01);
		compare({5'h0, general_output[7:5]}, 8'h01, "out5 alert");
		drive(8'h0f, 8'h02);
		compare({5'h0, general_output[7:5]}, 8'h03, "out6 alert");
		drive(8'h0f, 8'h04);
		compare({5'h0, general_output[7:5]}, 8'h07, "out7 alert");
		drive(8'h0f, 8'h00);
		compare({5'h0, general_output[7:5]}, 8'h07, "hold after alert");
		// Output 7 disabled keeps its level while 5 and 6 relaunch low
		reg_write(`OEUC_ADDR_TRIG_VAL, 8'h00);
		reg_write(`OEUC_ADDR_TRIG_EN, 8'h60);
		drive(8'h0f, 8'h07);
		compare({5'h0, general_output[7:5]}, 8'h04, "alert enable");
		// Launched levels read back, then enables on outputs without that update
		expect_read(`OEUC_ADDR_OUT_LEVELS, {3'b100, 1'b0, fall_exp}, "level readback");
		reg_write(`OEUC_ADDR_TRIG_EN, 8'h1f);
		reg_write(`OEUC_ADDR_TRIG_VAL, 8'hff);
		reg_write(`OEUC_ADDR_ZC_EN, 8'hf0);
		expect_read(`OEUC_ADDR_TRIG_EN, 8'h1f, "alert enable readback");
		expect_read(`OEUC_ADDR_TRIG_VAL, 8'hff, "launch level readback");
		expect_read(`OEUC_ADDR_ZC_EN, 8'hf0, "zc enable readback");
		drive(8'hf0, 8'hff);
		compare(general_output, {3'b100, 1'b0, fall_exp}, "enables without effect");
		// Reset in mid-run clears the outputs and restores the registers
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		compare(general_output, 8'h00, "outputs after second reset");
		expect_read(`OEUC_ADDR_OUT5_MASK, `OEUC_RST_OUT5_MASK, "out5 mask after reset");
		expect_read(`OEUC_ADDR_ZC_EN, `OEUC_RST_ZERO, "zc enable after reset");
		conclude();
	end
endmodule
`default_nettype wire
